// file: verilog/mcd_pkg.sv
// Shared constants, types and decode functions of the multiphase clock divider
package mcd_pkg;

  // ----------------------------------------------------------------
  // Three-state selection pin codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TRI_LOW  = 2'h0;  // Pin grounded
  localparam logic [1:0] TRI_OPEN = 2'h1;  // Pin floating
  localparam logic [1:0] TRI_HIGH = 2'h2;  // Pin tied to supply

  // ----------------------------------------------------------------
  // Divider ratios and timing
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W       = 7;
  localparam logic [6:0]  N_DIV_LOW   = 7'h01;  // Divide by 1
  localparam logic [6:0]  N_DIV_OPEN  = 7'h0A;  // Divide by 10
  localparam logic [6:0]  N_DIV_HIGH  = 7'h64;  // Divide by 100
  localparam int unsigned MASTER_CLKS = 2;      // Clock cycles per master period
  localparam int unsigned MOD_PRESCALE    = 3200;  // Master periods per spread step
  localparam int unsigned MOD_STEP_CYCLES = MOD_PRESCALE * MASTER_CLKS;
  localparam logic [9:0]  CFG_SETTLE  = 10'h3FF;   // Cycles before config counts as steady

  // ----------------------------------------------------------------
  // Spread modulation source
  // ----------------------------------------------------------------
  localparam int unsigned LFSR_W    = 9;
  localparam int unsigned CODE_W    = 7;
  localparam logic [8:0]  LFSR_SEED = 9'h001;
  localparam int unsigned TAP_HI    = 8;
  localparam int unsigned TAP_LO    = 4;
  localparam logic [10:0] ACC_SPAN  = 11'h400;  // Edge-rate accumulator full scale

  // ----------------------------------------------------------------
  // Lane-count modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MCD_LANE2 = 3'h1,
    MCD_LANE3 = 3'h2,
    MCD_LANE4 = 3'h4
  } mcd_lane_e;

  // Ratio pin to terminal count of the half-period counter (N - 1)
  function automatic logic [6:0] half_limit(input logic [1:0] sel);
    unique case (sel)
      TRI_OPEN: half_limit = N_DIV_OPEN - 7'h01;
      TRI_HIGH: half_limit = N_DIV_HIGH - 7'h01;
      default:  half_limit = N_DIV_LOW - 7'h01;
    endcase
  endfunction : half_limit

  // Lane-count pin to mode
  function automatic mcd_lane_e lane_decode(input logic [1:0] sel);
    unique case (sel)
      TRI_OPEN: lane_decode = MCD_LANE3;
      TRI_HIGH: lane_decode = MCD_LANE4;
      default:  lane_decode = MCD_LANE2;
    endcase
  endfunction : lane_decode

endpackage : mcd_pkg

// file: verilog/mcd_mod_if.sv
// Link between the phase core and the spread modulation source
`timescale 1ns/100ps
interface mcd_mod_if;
  logic       enable;     // Spread modulation on
  logic       edge_tick;  // Master half-period edge allowed this cycle
  logic [6:0] code;       // Modulation code

  modport src (input enable, output edge_tick, output code);
  modport snk (output enable, input edge_tick, input code);
endinterface : mcd_mod_if

// file: verilog/mcd_spread_gen.sv
// Pseudorandom spread source and down-only master edge gating
`timescale 1ns/100ps
module mcd_spread_gen #(
  parameter int unsigned STEP_CYCLES = mcd_pkg::MOD_STEP_CYCLES
) (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_q_in,
  input wire logic ce_in,
  // Link to the phase core
  mcd_mod_if.src   mif
);

  localparam int unsigned PW = $clog2(STEP_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(STEP_CYCLES - 1);

  if (STEP_CYCLES < 2) begin : g_chk
    $error("STEP_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [8:0]    lfsr;
    logic [PW-1:0] pre;
    logic [9:0]    acc;
    logic          tick;
    logic [6:0]    code;
  } mcd_spread_s;

  mcd_spread_s state_reg;
  mcd_spread_s state_next;
  logic [10:0] sum;
  logic        fb;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    sum = {1'b0, state_reg.acc} + (mcd_pkg::ACC_SPAN - {4'h0, state_reg.code});
    fb  = state_reg.lfsr[mcd_pkg::TAP_HI] ^ state_reg.lfsr[mcd_pkg::TAP_LO]
          ^ (state_reg.lfsr[7:0] == 8'h00);  // Zero-state insert gives a 512-step cycle
    if (!mif.enable) begin
      state_next.lfsr = mcd_pkg::LFSR_SEED;
      state_next.pre  = '0;
      state_next.acc  = '0;
      state_next.tick = 1'b1;
      state_next.code = 7'h00;
    end else begin
      // Carry rate is (1024 - code) / 1024, never above one edge per cycle
      state_next.tick = sum[10];
      state_next.acc  = sum[9:0];
      if (state_reg.pre == PRE_LAST) begin
        state_next.pre  = '0;
        state_next.lfsr = {state_reg.lfsr[7:0], fb};
      end else begin
        state_next.pre = state_reg.pre + PW'(1);
      end
      state_next.code = state_next.lfsr[6:0];
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_q_in) begin
    if (!rst_q_in) begin
      state_reg <= '{lfsr: mcd_pkg::LFSR_SEED, pre: '0, acc: 10'h000,
                     tick: 1'b1, code: 7'h00};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign mif.edge_tick = state_reg.tick;
  assign mif.code      = state_reg.code;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mod_off;
    @(posedge clk_in) disable iff (!rst_q_in)
    (ce_in && !mif.enable) |=> (mif.edge_tick && mif.code == 7'h00 && state_reg.pre == '0);
  endproperty
  a_mod_off: assert property (p_mod_off) else $error("modulation not idle when off");

  property p_step_time;
    @(posedge clk_in) disable iff (!rst_q_in)
    (mif.enable && $past(mif.enable) && $past(ce_in) && $changed(state_reg.lfsr))
      |-> ($past(state_reg.pre) == PRE_LAST && mif.code == state_reg.lfsr[6:0]);
  endproperty
  a_step_time: assert property (p_step_time) else $error("lfsr stepped off prescale");

endmodule : mcd_spread_gen

// file: verilog/mcd_clock_divider.sv
// Programmable divider and multiphase generator of the oscillator back end
`timescale 1ns/100ps
// Notes on behaviour
// - Master clock feeds the divider; divider output feeds the multiphase generator.
// - Ratio pin grounded, floating, high divides by 1, 10, 100.
// - Divide-by-one in two-phase mode toggles the tap flip-flops on every edge tick, at the master rate.
// - Lane pin low, floating, high picks 2, 3, 4 phases, extra factor 1, 3, 4.
// - Three- and four-phase modes divide the divider output further.
// - Output duty cycle depends on the phase mode.
// - Four taps, each from its own output flip-flop.
// - Spread pin low disables modulation and stops the modulation logic.
// - Modulation only lowers frequency, never above nominal.
// - Two-phase: tap 2 inverts tap 1, taps 3 and 4 copy 1 and 2.
// - Three-phase: shift register, 33.3% duty, 120 degree lags, tap 4 low.
// - Four-phase: 50% duty, each tap lags the previous by 90 degrees.
// - Modulation from 9-bit LFSR every 3200 master periods, low 7 bits, 512 steps.
module mcd_clock_divider #(
  parameter int unsigned STEP_CYCLES = mcd_pkg::MOD_STEP_CYCLES
) (
  // Master oscillator clock, reset and enable
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ce_in,
  // Static selections
  input  wire logic [1:0] div_ratio_sel_in,
  input  wire logic [1:0] lane_count_select_in,
  input  wire logic       spread_depth_pin_in,
  // Clock taps
  output logic            clock_tap_1_out,
  output logic            clock_tap_2_out,
  output logic            clock_tap_3_out,
  output logic            clock_tap_4_out,
  // Modulation status
  output logic            spread_spectrum_mode_out,
  output logic [6:0]      spread_code_out
);

  typedef struct packed {
    mcd_pkg::mcd_lane_e lane;
    logic [6:0]         lim;
    logic [6:0]         half_cnt;
    logic               div_level;
    logic [2:0]         ring3;
    logic [1:0]         quad;
    logic [3:0]         taps;
    logic               spread_en;
  } mcd_core_s;

  mcd_core_s  state_reg;
  mcd_core_s  state_next;
  logic [1:0] rst_sync_reg;
  logic       rst_q;
  logic       rise;

  mcd_mod_if mif ();

  // ----------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Spread modulation source
  // ----------------------------------------------------------------
  mcd_spread_gen #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_spread (
    .clk_in   (clk_in),
    .rst_q_in (rst_q),
    .ce_in    (ce_in),
    .mif      (mif)
  );

  assign mif.enable = state_reg.spread_en;

  // ----------------------------------------------------------------
  // Divider and multiphase next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next           = state_reg;
    rise                 = 1'b0;
    state_next.lane      = mcd_pkg::lane_decode(lane_count_select_in);
    state_next.lim       = mcd_pkg::half_limit(div_ratio_sel_in);
    state_next.spread_en = spread_depth_pin_in;
    // Each edge tick is one master half-period; N ticks per divided half-period
    if (mif.edge_tick) begin
      if (state_reg.half_cnt >= state_reg.lim) begin
        state_next.half_cnt  = 7'h00;
        state_next.div_level = ~state_reg.div_level;
        rise                 = ~state_reg.div_level;
      end else begin
        state_next.half_cnt = state_reg.half_cnt + 7'h01;
      end
    end
    // Phase registers advance on divided rising edges
    if (rise) begin
      state_next.ring3 = {state_reg.ring3[1:0], state_reg.ring3[2]};
      state_next.quad  = {state_reg.quad[0], ~state_reg.quad[1]};
    end
    // Tap patterns per mode set the duty cycle
    unique case (state_reg.lane)
      mcd_pkg::MCD_LANE2: state_next.taps = {~state_next.div_level, state_next.div_level,
                                             ~state_next.div_level, state_next.div_level};
      mcd_pkg::MCD_LANE3: state_next.taps = {1'b0, state_next.ring3};
      mcd_pkg::MCD_LANE4: state_next.taps = {~state_next.quad[1], ~state_next.quad[0],
                                             state_next.quad[1], state_next.quad[0]};
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      state_reg <= '{lane: mcd_pkg::MCD_LANE2, lim: 7'h00, half_cnt: 7'h00,
                     div_level: 1'b0, ring3: 3'h1, quad: 2'h0, taps: 4'hA,
                     spread_en: 1'b0};
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // Tap and status outputs, each from its own flip-flop
  assign clock_tap_1_out          = state_reg.taps[0];
  assign clock_tap_2_out          = state_reg.taps[1];
  assign clock_tap_3_out          = state_reg.taps[2];
  assign clock_tap_4_out          = state_reg.taps[3];
  assign spread_spectrum_mode_out = state_reg.spread_en;
  assign spread_code_out          = mif.code;

  // ----------------------------------------------------------------
  // Check helpers: steady configuration and tap 1 run length
  // ----------------------------------------------------------------
  logic [9:0] cfg_age_reg;
  logic [3:0] cfg_d_reg;
  logic       tap1_d_reg;
  logic [9:0] run_len_reg;
  logic       steady;
  logic       tap1_edge;

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      cfg_age_reg <= 10'h000;
      cfg_d_reg   <= 4'h0;
      tap1_d_reg  <= 1'b0;
      run_len_reg <= 10'h000;
    end else if (ce_in) begin
      cfg_d_reg  <= {div_ratio_sel_in, lane_count_select_in};
      tap1_d_reg <= state_reg.taps[0];
      if (cfg_d_reg != {div_ratio_sel_in, lane_count_select_in}) begin
        cfg_age_reg <= 10'h000;
      end else if (cfg_age_reg != mcd_pkg::CFG_SETTLE) begin
        cfg_age_reg <= cfg_age_reg + 10'h001;
      end
      if (state_reg.taps[0] != tap1_d_reg) begin
        run_len_reg <= 10'h001;
      end else if (run_len_reg != 10'h3FF) begin
        run_len_reg <= run_len_reg + 10'h001;
      end
    end
  end
  assign steady    = ce_in && cfg_age_reg == mcd_pkg::CFG_SETTLE;
  assign tap1_edge = steady && state_reg.taps[0] != tap1_d_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_div_one;
    @(posedge clk_in) disable iff (!rst_q)
    (steady && mif.edge_tick && state_reg.lim == 7'h00
      && state_reg.lane == mcd_pkg::MCD_LANE2) |=> (clock_tap_1_out != $past(clock_tap_1_out));
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide-by-one tap lagged master");

  property p_ratio;
    @(posedge clk_in) disable iff (!rst_q)
    (tap1_edge && !state_reg.spread_en && state_reg.lane == mcd_pkg::MCD_LANE2)
      |-> run_len_reg == {3'h0, state_reg.lim} + 10'h001;
  endproperty
  a_ratio: assert property (p_ratio) else $error("half period differs from ratio");

  property p_down_only;
    @(posedge clk_in) disable iff (!rst_q)
    (tap1_edge && state_reg.spread_en && state_reg.lane == mcd_pkg::MCD_LANE2)
      |-> run_len_reg >= {3'h0, state_reg.lim} + 10'h001;
  endproperty
  a_down_only: assert property (p_down_only) else $error("spread raised frequency");

  property p_quad_div;
    @(posedge clk_in) disable iff (!rst_q)
    (tap1_edge && !state_reg.spread_en && state_reg.lane == mcd_pkg::MCD_LANE4)
      |-> run_len_reg == ({3'h0, state_reg.lim} + 10'h001) << 2;
  endproperty
  a_quad_div: assert property (p_quad_div) else $error("four-phase half period wrong");

  property p_two_phase;
    @(posedge clk_in) disable iff (!rst_q)
    (steady && state_reg.lane == mcd_pkg::MCD_LANE2)
      |=> (clock_tap_2_out == !clock_tap_1_out && clock_tap_3_out == clock_tap_1_out
           && clock_tap_4_out == clock_tap_2_out);
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("two-phase taps wrong");

  property p_three_phase;
    @(posedge clk_in) disable iff (!rst_q)
    (steady && state_reg.lane == mcd_pkg::MCD_LANE3)
      |=> (!clock_tap_4_out && $onehot({clock_tap_3_out, clock_tap_2_out, clock_tap_1_out}));
  endproperty
  a_three_phase: assert property (p_three_phase) else $error("three-phase taps wrong");

  property p_four_phase;
    @(posedge clk_in) disable iff (!rst_q)
    (steady && state_reg.lane == mcd_pkg::MCD_LANE4 && $rose(clock_tap_1_out))
      |-> (!clock_tap_2_out && clock_tap_3_out == 1'b0 && clock_tap_4_out);
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("four-phase order wrong");

endmodule : mcd_clock_divider

// file: testbench/mcd_load_model.sv
// Clocked load model that times the phase taps it receives
`timescale 1ns/100ps
module mcd_load_model (
  // Clock and clear
  input  wire logic clk_in,
  input  wire logic clr_in,
  // Observed taps
  input  wire logic tap_a_in,
  input  wire logic tap_b_in,
  // Measurements in clock cycles
  output int        per_out,
  output int        high_out,
  output int        lag_out,
  output int        min_per_out,
  output int        rises_out
);
  logic a_reg;
  logic b_reg;
  int   since_reg;

  // Edge timing of both taps, sampled on the rising clock as a real load would
  always_ff @(posedge clk_in) begin
    a_reg <= tap_a_in;
    b_reg <= tap_b_in;
    if (clr_in) begin
      since_reg   <= 0;
      rises_out   <= 0;
      per_out     <= 0;
      high_out    <= 0;
      lag_out     <= 0;
      min_per_out <= 32'h7FFFFFFF;
    end else begin
      since_reg <= since_reg + 1;
      if (tap_a_in && !a_reg) begin
        since_reg <= 0;
        rises_out <= rises_out + 1;
        if (rises_out > 0) begin
          per_out <= since_reg + 1;
          if (since_reg + 1 < min_per_out) min_per_out <= since_reg + 1;
        end
      end
      if (!tap_a_in && a_reg && rises_out > 0) high_out <= since_reg + 1;
      if (tap_b_in && !b_reg && rises_out > 0) lag_out <= since_reg + 1;
    end
  end
endmodule : mcd_load_model

// file: testbench/tb_top.sv
// Self-checking testbench of the multiphase clock divider
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus, observation and counters
  // ----------------------------------------------------------------
  localparam int STEP = 16;
  logic       clk_in   = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       ce_in    = 1'b1;
  logic [1:0] div_sel  = 2'h0;
  logic [1:0] lane_sel = 2'h0;
  logic       spread   = 1'b0;
  logic       clr      = 1'b1;
  logic       tap1, tap2, tap3, tap4, mode;
  logic [6:0] code;
  int         per, high, lag, min_per, rises;
  int         mismatches  = 0;
  int         comparisons = 0;

  // Free-running 250 MHz clock
  initial forever #2 clk_in = ~clk_in;

  mcd_clock_divider #(.STEP_CYCLES(STEP)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .div_ratio_sel_in(div_sel), .lane_count_select_in(lane_sel),
    .spread_depth_pin_in(spread), .clock_tap_1_out(tap1), .clock_tap_2_out(tap2),
    .clock_tap_3_out(tap3), .clock_tap_4_out(tap4),
    .spread_spectrum_mode_out(mode), .spread_code_out(code));

  mcd_load_model load (
    .clk_in(clk_in), .clr_in(clr), .tap_a_in(tap1), .tap_b_in(tap2), .per_out(per),
    .high_out(high), .lag_out(lag), .min_per_out(min_per), .rises_out(rises));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [6:0] exp, logic [6:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk

  task automatic chk_i(string nm, int exp, int got);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_i

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cycles(int n);
    repeat (n) @(negedge clk_in);
  endtask : cycles

  // Selections are applied while in reset and then left alone
  task automatic start(logic [1:0] d, logic [1:0] l, logic s);
    @(negedge clk_in);
    rst_b_in = 1'b0;
    div_sel  = d;
    lane_sel = l;
    spread   = s;
    cycles(4);
    rst_b_in = 1'b1;
    cycles(12);
    clr = 1'b1;
    cycles(1);
    clr = 1'b0;
  endtask : start

  task automatic wait_rise;
    int n;
    logic prev;
    prev = tap1;
    for (n = 0; n < 500 && !(tap1 === 1'b1 && prev === 1'b0); n++) begin
      prev = tap1;
      @(negedge clk_in);
    end
    if (n == 500) begin
      mismatches++;
      $display("Error tap1_rise expected 1 seen 0");
      tally_and_finish();
    end
  endtask : wait_rise

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals;
    cycles(20);
    chk("tap_levels", 7'h0A, {3'h0, tap4, tap3, tap2, tap1});
    chk("code", 7'h00, code);
    chk("mode", 7'h00, {6'h00, mode});
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_two_phase;
    int h, bad;
    for (int i = 0; i < 3; i++) begin
      h = (i == 0) ? 1 : (i == 1) ? 10 : 100;
      start(2'(i), 2'h0, 1'b0);
      cycles(6 * h + 6);
      chk_i("period", 2 * h, per);
      chk_i("high", h, high);
      bad = 0;
      repeat (40) begin
        @(negedge clk_in);
        if (tap2 !== ~tap1 || tap3 !== tap1 || tap4 !== tap2) bad++;
      end
      chk_i("two_phase_bad", 0, bad);
    end
    $display("test two_phase done");
  endtask : t_two_phase

  task automatic t_three_phase;
    int bad;
    start(2'h1, 2'h1, 1'b0);
    // Long enough for the steady-configuration checks in the design to arm
    cycles(1100);
    chk_i("period", 60, per);
    chk_i("high", 20, high);
    chk_i("lag", 20, lag);
    bad = 0;
    repeat (120) begin
      @(negedge clk_in);
      if (tap4 !== 1'b0 || (tap1 && tap3) || (tap1 && tap2)) bad++;
    end
    chk_i("three_phase_bad", 0, bad);
    $display("test three_phase done");
  endtask : t_three_phase

  task automatic t_four_phase;
    int bad;
    start(2'h1, 2'h2, 1'b0);
    // Long enough for the steady-configuration checks in the design to arm
    cycles(1100);
    chk_i("period", 80, per);
    chk_i("high", 40, high);
    chk_i("lag", 20, lag);
    bad = 0;
    repeat (80) begin
      @(negedge clk_in);
      if (tap3 !== ~tap1 || tap4 !== ~tap2) bad++;
    end
    chk_i("four_phase_bad", 0, bad);
    $display("test four_phase done");
  endtask : t_four_phase

  task automatic t_freeze;
    logic [6:0] snap;
    start(2'h1, 2'h0, 1'b0);
    wait_rise();
    ce_in = 1'b0;
    snap = {3'h0, tap4, tap3, tap2, tap1};
    cycles(15);
    chk("frozen_taps", snap, {3'h0, tap4, tap3, tap2, tap1});
    ce_in = 1'b1;
    clr = 1'b1;
    cycles(1);
    clr = 1'b0;
    cycles(70);
    chk_i("period", 20, per);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_spread;
    logic [6:0] first, last;
    int changes;
    // Divide by 10 so that a swallowed edge shows as a longer half period
    start(2'h1, 2'h0, 1'b1);
    chk("mode", 7'h01, {6'h00, mode});
    first = code;
    last = code;
    changes = 0;
    repeat (512) begin
      cycles(STEP);
      if (code !== last) changes++;
      last = code;
    end
    chk("code_repeat", first, code);
    chk_i("code_moves", 1, int'(changes > 100));
    chk_i("min_period", 1, int'(min_per >= 20));
    chk_i("slowed", 1, int'(rises < 512 * STEP / 20));
    start(2'h0, 2'h0, 1'b0);
    cycles(2000);
    chk("code_off", 7'h00, code);
    chk("mode_off", 7'h00, {6'h00, mode});
    chk_i("full_rate", 1, int'(rises >= 999 && rises <= 1000));
    $display("test spread done");
  endtask : t_spread

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    t_reset_vals();
    t_two_phase();
    t_three_phase();
    t_four_phase();
    t_freeze();
    t_spread();
    tally_and_finish();
  end
endmodule : tb_top
